/* logic/mfc_pkg.sv */
// Constants, types and helpers of the Modbus frame check and error reply block
package mfc_pkg;
  // Characters framing an ASCII-mode frame
  localparam logic [7:0] MFC_CH_START = 8'h3a; // Colon start character
  localparam logic [7:0] MFC_CH_CR = 8'h0d;
  localparam logic [7:0] MFC_CH_LF = 8'h0a;
  // Check arithmetic
  localparam logic [15:0] MFC_CRC_INIT = 16'hffff;
  localparam logic [15:0] MFC_CRC_POLY = 16'ha001;
  localparam logic [7:0] MFC_SUM_INIT = 8'h00;
  localparam int MFC_CRC_STEPS = 8;
  // Reply fields and error codes
  localparam logic [7:0] MFC_EXC_FLAG = 8'h80;
  localparam logic [7:0] MFC_BCAST_ADDR = 8'h00;
  localparam logic [7:0] MFC_ERR_NONE = 8'h00;
  localparam logic [7:0] MFC_ERR_FUNC = 8'h01;
  localparam logic [7:0] MFC_ERR_ADDR = 8'h02;
  localparam logic [7:0] MFC_ERR_RANGE = 8'h03;
  localparam logic [7:0] MFC_ERR_EXEC = 8'h04;
  // Frame limits and timing
  localparam logic [7:0] MFC_MIN_LEN_ASCII = 8'h03; // Address, function, LRC
  localparam logic [7:0] MFC_MIN_LEN_RTU = 8'h04; // Address, function, CRC pair
  localparam logic [1:0] MFC_IDLE_CHARS = 2'h0; // Idle gap is four characters: shift by 2
  localparam int MFC_IDLE_SHIFT = 2;
  localparam int MFC_IDLE_W = 18;
  // Reply buffer layout
  localparam logic [2:0] MFC_TX_LAST_ASCII = 3'h3; // Address, code, error, LRC
  localparam logic [2:0] MFC_TX_LAST_RTU = 3'h4; // Address, code, error, CRC lo, CRC hi
  // FIFO shape
  localparam int MFC_FIFO_W = 8;
  localparam int MFC_FIFO_DEPTH = 32;

  // Header of a received frame
  typedef struct packed {
    logic [7:0] station;
    logic [7:0] func;
  } mfc_hdr_t;

  // Reply sequencer states
  typedef enum logic [2:0] {
    MFC_TX_IDLE = 3'b000,
    MFC_TX_START = 3'b001,
    MFC_TX_HI = 3'b010,
    MFC_TX_LO = 3'b011,
    MFC_TX_CR = 3'b100,
    MFC_TX_LF = 3'b101
  } mfc_tx_state_t;

  // One byte absorbed into the CRC: combine, then eight conditional shifts
  function automatic logic [15:0] mfc_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < MFC_CRC_STEPS; i++) begin
      c = c[0] ? ((c >> 1) ^ MFC_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // Uppercase hex character to {valid, nibble}
  function automatic logic [4:0] mfc_hex_val(input logic [7:0] ch);
    logic [4:0] r;
    r = 5'h00;
    if (ch >= 8'h30 && ch <= 8'h39) begin
      r = {1'b1, ch[3:0]};
    end else if (ch >= 8'h41 && ch <= 8'h46) begin
      r = {1'b1, ch[3:0] + 4'h9};
    end
    return r;
  endfunction

  // Nibble to uppercase hex character
  function automatic logic [7:0] mfc_hex_char(input logic [3:0] n);
    return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction
endpackage

/* logic/mfc_top.sv */
// Modbus slave frame check, end-of-frame detection and exception reply builder
// Behaviour
// - ASCII check is two's complement of the byte sum modulo 256.
// - RTU CRC accumulator starts at all ones before the first byte.
// - Each byte is XORed into the CRC low eight bits first.
// - Shift right once; XOR with A001 when the dropped bit was one.
// - Eight shift steps per byte before the next byte.
// - CRC runs over address through last data byte; final value is the check.
// - RTU sends CRC low byte first, then high byte.
// - ASCII frame ends with carriage return then line feed.
// - RTU frame ends after line idle longer than four character times.
// - Bad address or range gives an exception reply, device keeps running.
// - Interrupted, corrupt or bad-check frames are dropped with no reply.
// - Exception reply: station, function plus 80h, error code, check.
// - Error codes 00 normal, 01 unknown function, 02 missing address.
// - Error codes 03 value out of range, 04 execution not completed.
// - Station address 00 is broadcast: acted on, never answered.

// Synchronous FIFO with valid and ready on both sides
module mfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic push, pop;

  // Flags and pointer updates
  always_comb begin
    in_ready = (count_ff != DEPTH[AW:0]);
    out_valid = (count_ff != '0);
    out_data = mem_ff[rd_ptr_ff];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // Pointer and storage registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
    end
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end
endmodule

module mfc_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic ascii_mode,
  input wire logic [7:0] station_no,
  input wire logic [15:0] char_cycles,
  // Received characters from the UART
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Decoded frame bytes and verdict to the command executor
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic frame_good,
  output logic frame_bad,
  output mfc_pkg::mfc_hdr_t frame_hdr,
  // Executor outcome for the last good frame
  input wire logic exec_done,
  input wire logic [7:0] exec_code,
  // Reply characters to the UART
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready
);
  import mfc_pkg::*;

  logic in_frame_ff, nxt_in_frame;
  logic half_ff, nxt_half;
  logic [3:0] nib_ff, nxt_nib;
  logic cr_ff, nxt_cr;
  logic err_ff, nxt_err;
  logic ignore_ff, nxt_ignore;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] sum_ff, nxt_sum;
  logic [15:0] crc_ff, nxt_crc;
  logic [MFC_IDLE_W-1:0] idle_ff, nxt_idle;
  mfc_hdr_t hdr_ff, nxt_hdr;
  logic byte_valid_ff, nxt_byte_valid;
  logic [7:0] byte_data_ff, nxt_byte_data;
  logic good_ff, nxt_good;
  logic bad_ff, nxt_bad;
  logic got_byte;
  logic [7:0] got_val;
  logic eof;
  logic [4:0] hexv;
  logic [MFC_IDLE_W-1:0] idle_limit;
  logic [7:0] min_len;
  logic check_ok;

  // Receive path: character decode, check accumulation, end-of-frame
  always_comb begin
    nxt_in_frame = in_frame_ff;
    nxt_half = half_ff;
    nxt_nib = nib_ff;
    nxt_cr = cr_ff;
    nxt_err = err_ff;
    nxt_ignore = ignore_ff;
    nxt_cnt = cnt_ff;
    nxt_sum = sum_ff;
    nxt_crc = crc_ff;
    nxt_idle = idle_ff;
    nxt_hdr = hdr_ff;
    nxt_byte_valid = 1'b0;
    nxt_byte_data = byte_data_ff;
    nxt_good = 1'b0;
    nxt_bad = 1'b0;
    got_byte = 1'b0;
    got_val = rx_data;
    eof = 1'b0;
    hexv = mfc_hex_val(rx_data);
    idle_limit = {2'b00, char_cycles} << MFC_IDLE_SHIFT;
    min_len = ascii_mode ? MFC_MIN_LEN_ASCII : MFC_MIN_LEN_RTU;
    check_ok = ascii_mode ? (sum_ff == MFC_SUM_INIT) : (crc_ff == 16'h0000);
    if (ascii_mode) begin
      if (rx_valid && rx_data == MFC_CH_START) begin
        // Colon restarts; an unfinished frame is dropped silently
        nxt_in_frame = 1'b1;
        nxt_half = 1'b0;
        nxt_cr = 1'b0;
        nxt_err = 1'b0;
        nxt_cnt = 8'h00;
        nxt_sum = MFC_SUM_INIT;
      end else if (rx_valid && in_frame_ff) begin
        if (cr_ff) begin
          if (rx_data == MFC_CH_LF) begin
            eof = 1'b1;
          end else begin
            nxt_err = 1'b1;
            nxt_cr = 1'b0;
          end
        end else if (rx_data == MFC_CH_CR) begin
          nxt_cr = 1'b1;
          if (half_ff) begin
            nxt_err = 1'b1;
          end
        end else if (hexv[4]) begin
          nxt_half = !half_ff;
          nxt_nib = hexv[3:0];
          if (half_ff) begin
            got_byte = 1'b1;
            got_val = {nib_ff, hexv[3:0]};
          end
        end else begin
          nxt_err = 1'b1;
        end
      end
    end else begin
      if (rx_valid) begin
        got_byte = 1'b1;
        nxt_idle = '0;
        if (!in_frame_ff) begin
          nxt_in_frame = 1'b1;
          nxt_err = 1'b0;
          nxt_cnt = 8'h00;
          nxt_crc = MFC_CRC_INIT;
        end
      end else if (in_frame_ff) begin
        if (idle_ff > idle_limit) begin
          eof = 1'b1;
        end else begin
          nxt_idle = idle_ff + 1'b1;
        end
      end
    end
    // Absorb one frame byte into both checks and the header
    if (got_byte) begin
      if (nxt_cnt == 8'h00) begin
        nxt_hdr.station = got_val;
        nxt_ignore = (got_val != station_no) && (got_val != MFC_BCAST_ADDR);
      end else if (nxt_cnt == 8'h01) begin
        nxt_hdr.func = got_val;
      end
      nxt_sum = (nxt_cnt == 8'h00 ? MFC_SUM_INIT : sum_ff) + got_val;
      nxt_crc = mfc_crc_byte((nxt_cnt == 8'h00) ? MFC_CRC_INIT : crc_ff, got_val);
      nxt_cnt = (cnt_ff == 8'hff) ? cnt_ff : nxt_cnt + 8'h01;
      nxt_byte_valid = (nxt_cnt == 8'h01) ? !nxt_ignore : !ignore_ff;
      nxt_byte_data = got_val;
    end
    // Verdict at end of frame; other stations get none
    if (eof) begin
      nxt_in_frame = 1'b0;
      nxt_cr = 1'b0;
      nxt_idle = '0;
      if (cnt_ff != 8'h00 && !ignore_ff) begin
        if (!err_ff && cnt_ff >= min_len && check_ok) begin
          nxt_good = 1'b1;
        end else begin
          nxt_bad = 1'b1;
        end
      end
    end
  end

  // Receive path registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_frame_ff <= 1'b0;
      half_ff <= 1'b0;
      nib_ff <= 4'h0;
      cr_ff <= 1'b0;
      err_ff <= 1'b0;
      ignore_ff <= 1'b0;
      cnt_ff <= 8'h00;
      sum_ff <= MFC_SUM_INIT;
      crc_ff <= MFC_CRC_INIT;
      idle_ff <= '0;
      hdr_ff <= '0;
      byte_valid_ff <= 1'b0;
      byte_data_ff <= 8'h00;
      good_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else begin
      in_frame_ff <= nxt_in_frame;
      half_ff <= nxt_half;
      nib_ff <= nxt_nib;
      cr_ff <= nxt_cr;
      err_ff <= nxt_err;
      ignore_ff <= nxt_ignore;
      cnt_ff <= nxt_cnt;
      sum_ff <= nxt_sum;
      crc_ff <= nxt_crc;
      idle_ff <= nxt_idle;
      hdr_ff <= nxt_hdr;
      byte_valid_ff <= nxt_byte_valid;
      byte_data_ff <= nxt_byte_data;
      good_ff <= nxt_good;
      bad_ff <= nxt_bad;
    end
  end

  assign byte_valid = byte_valid_ff;
  assign byte_data = byte_data_ff;
  assign frame_good = good_ff;
  assign frame_bad = bad_ff;
  assign frame_hdr = hdr_ff;

  mfc_tx_state_t st_ff, nxt_st;
  logic pend_ff, nxt_pend;
  logic [7:0] tb_ff [5];
  logic [7:0] nxt_tb [5];
  logic [2:0] idx_ff, nxt_idx;
  logic [2:0] last_idx;
  logic [7:0] exc_code;
  logic [15:0] reply_crc;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [7:0] f_in_data, f_out_data;
  logic tx_valid_ff, nxt_tx_valid;
  logic [7:0] tx_data_ff, nxt_tx_data;

  // Reply sequencer: builds exception frames into the FIFO
  always_comb begin
    nxt_st = st_ff;
    nxt_pend = pend_ff;
    nxt_idx = idx_ff;
    for (int i = 0; i < 5; i++) begin
      nxt_tb[i] = tb_ff[i];
    end
    last_idx = ascii_mode ? MFC_TX_LAST_ASCII : MFC_TX_LAST_RTU;
    exc_code = hdr_ff.func | MFC_EXC_FLAG;
    reply_crc = mfc_crc_byte(mfc_crc_byte(mfc_crc_byte(MFC_CRC_INIT, hdr_ff.station),
                exc_code), exec_code);
    f_in_valid = 1'b0;
    f_in_data = 8'h00;
    if (good_ff) begin
      nxt_pend = 1'b1;
    end else if (exec_done && pend_ff) begin
      nxt_pend = 1'b0;
      // Broadcast and normal outcomes never produce a reply here
      if (exec_code != MFC_ERR_NONE && hdr_ff.station != MFC_BCAST_ADDR
          && st_ff == MFC_TX_IDLE) begin
        nxt_tb[0] = hdr_ff.station;
        nxt_tb[1] = exc_code;
        nxt_tb[2] = exec_code;
        nxt_tb[3] = ascii_mode ? 8'h00 - (hdr_ff.station + exc_code + exec_code)
                               : reply_crc[7:0];
        nxt_tb[4] = reply_crc[15:8];
        nxt_idx = 3'h0;
        nxt_st = ascii_mode ? MFC_TX_START : MFC_TX_LO;
      end
    end
    case (st_ff)
      MFC_TX_IDLE: begin
        f_in_valid = 1'b0;
      end
      MFC_TX_START: begin
        f_in_valid = 1'b1;
        f_in_data = MFC_CH_START;
        if (f_in_ready) begin
          nxt_st = MFC_TX_HI;
        end
      end
      MFC_TX_HI: begin
        f_in_valid = 1'b1;
        f_in_data = mfc_hex_char(tb_ff[idx_ff][7:4]);
        if (f_in_ready) begin
          nxt_st = MFC_TX_LO;
        end
      end
      MFC_TX_LO: begin
        f_in_valid = 1'b1;
        f_in_data = ascii_mode ? mfc_hex_char(tb_ff[idx_ff][3:0]) : tb_ff[idx_ff];
        if (f_in_ready) begin
          nxt_idx = idx_ff + 3'h1;
          if (idx_ff == last_idx) begin
            nxt_st = ascii_mode ? MFC_TX_CR : MFC_TX_IDLE;
          end else begin
            nxt_st = ascii_mode ? MFC_TX_HI : MFC_TX_LO;
          end
        end
      end
      MFC_TX_CR: begin
        f_in_valid = 1'b1;
        f_in_data = MFC_CH_CR;
        if (f_in_ready) begin
          nxt_st = MFC_TX_LF;
        end
      end
      MFC_TX_LF: begin
        f_in_valid = 1'b1;
        f_in_data = MFC_CH_LF;
        if (f_in_ready) begin
          nxt_st = MFC_TX_IDLE;
        end
      end
      default: begin
        nxt_st = MFC_TX_IDLE;
      end
    endcase
    // Output register drained by the UART
    f_out_ready = !tx_valid_ff || tx_ready;
    nxt_tx_valid = tx_valid_ff;
    nxt_tx_data = tx_data_ff;
    if (f_out_ready) begin
      nxt_tx_valid = f_out_valid;
      nxt_tx_data = f_out_valid ? f_out_data : tx_data_ff;
    end
  end

  // Reply sequencer registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= MFC_TX_IDLE;
      pend_ff <= 1'b0;
      idx_ff <= 3'h0;
      for (int i = 0; i < 5; i++) begin
        tb_ff[i] <= 8'h00;
      end
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      pend_ff <= nxt_pend;
      idx_ff <= nxt_idx;
      for (int i = 0; i < 5; i++) begin
        tb_ff[i] <= nxt_tb[i];
      end
      tx_valid_ff <= nxt_tx_valid;
      tx_data_ff <= nxt_tx_data;
    end
  end

  // Reply character buffer
  mfc_fifo #(
    .WIDTH(MFC_FIFO_W),
    .DEPTH(MFC_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  assign tx_valid = tx_valid_ff;
  assign tx_data = tx_data_ff;
endmodule

/* verification/mfc_monitor.sv */
// Port checker for the frame check and exception reply block
module mfc_monitor
  import mfc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Configuration
  input wire logic ascii_mode,
  input wire logic [7:0] station_no,
  input wire logic [15:0] char_cycles,
  // Receive side
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_good,
  input wire logic frame_bad,
  input wire mfc_pkg::mfc_hdr_t frame_hdr,
  // Executor and reply side
  input wire logic exec_done,
  input wire logic [7:0] exec_code,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready
);
  import mfc_pkg::*;
  logic [17:0] idle_ff;
  logic [17:0] nxt_idle;
  logic pend_ff;
  logic nxt_pend;
  logic first_ff;
  logic nxt_first;
  // Idle cycles, pending good frame, next byte opens a frame
  always_comb begin
    nxt_idle = rx_valid ? 18'h00000 : idle_ff + {17'h00000, idle_ff != 18'h3ffff};
    nxt_pend = frame_good | (pend_ff & !exec_done);
    nxt_first = frame_good | frame_bad | (first_ff & !byte_valid)
      | (ascii_mode & rx_valid & (rx_data == MFC_CH_START));
  end
  // Helper registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idle_ff <= 18'h00000;
      pend_ff <= 1'b0;
      first_ff <= 1'b1;
    end else begin
      idle_ff <= nxt_idle;
      pend_ff <= nxt_pend;
      first_ff <= nxt_first;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_one_verdict: assert property (!(frame_good && frame_bad))
    else $error("good and bad verdict together");
  chk_ascii_end: assert property (frame_good && ascii_mode |->
    $past(rx_valid) && $past(rx_data) == MFC_CH_LF) else $error("ascii verdict not after lf");
  chk_rtu_gap: assert property (frame_good && !ascii_mode |->
    idle_ff > {char_cycles, 2'b00}) else $error("rtu verdict before idle gap");
  chk_ascii_pair: assert property (byte_valid && ascii_mode |-> $past(rx_valid))
    else $error("ascii byte without second char");
  chk_first_byte: assert property (byte_valid && first_ff |->
    byte_data == station_no || byte_data == MFC_BCAST_ADDR) else $error("foreign frame shown");
  chk_hdr_good: assert property (frame_good |-> frame_hdr.station == station_no ||
    frame_hdr.station == MFC_BCAST_ADDR) else $error("foreign frame accepted");
  chk_reply_start: assert property (exec_done && pend_ff && exec_code != MFC_ERR_NONE &&
    frame_hdr.station != MFC_BCAST_ADDR && !tx_valid |-> ##3 tx_valid &&
    tx_data == (ascii_mode ? MFC_CH_START : frame_hdr.station)) else $error("reply start wrong");
  chk_bcast_quiet: assert property (exec_done && frame_hdr.station == MFC_BCAST_ADDR &&
    !tx_valid |=> !tx_valid [*6]) else $error("reply to broadcast");
  chk_none_quiet: assert property (exec_done && exec_code == MFC_ERR_NONE && !tx_valid
    |=> !tx_valid [*6]) else $error("reply to normal outcome");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply char dropped while stalled");
  // Main scenarios
  cov_ascii_good: cover property (frame_good && ascii_mode);
  cov_rtu_good: cover property (frame_good && !ascii_mode);
  cov_bad: cover property (frame_bad);
  cov_stall: cover property (tx_valid && !tx_ready);
endmodule

bind mfc_top mfc_monitor u_mon (
  .clk_sys(clk_sys), .rst(rst), .ascii_mode(ascii_mode), .station_no(station_no),
  .char_cycles(char_cycles), .rx_valid(rx_valid), .rx_data(rx_data),
  .byte_valid(byte_valid), .byte_data(byte_data), .frame_good(frame_good),
  .frame_bad(frame_bad), .frame_hdr(frame_hdr), .exec_done(exec_done),
  .exec_code(exec_code), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
);

/* verification/mfc_master_model.sv */
// Upper computer model: sends request frames, takes reply characters
module mfc_master_model (
  // Clock and pacing
  input wire logic clk_sys,
  input wire logic stall,
  // Request characters to the slave
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Reply characters from the slave
  input wire logic tx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import mfc_pkg::*;
  // Quiet line at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // Reply side stalls at random
  always @(negedge clk_sys) tx_ready <= !(stall && tx_valid);
  // Nibble to uppercase hex character
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return n < 4'ha ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction
  // One character per cycle
  task automatic send_char(input logic [7:0] c);
    @(negedge clk_sys);
    rx_valid = 1'b1;
    rx_data = c;
  endtask
  // Released line shows the inverse of the last value
  task automatic release_line(input int gap);
    @(negedge clk_sys);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    repeat (gap) @(negedge clk_sys);
  endtask
  // Start, bytes with check, end marker or idle gap
  task automatic send_frame(input logic [7:0] b[$], input logic asc, input int gap);
    if (asc) send_char(MFC_CH_START);
    foreach (b[i]) begin
      if (asc) begin
        send_char(hex_ch(b[i][7:4]));
        send_char(hex_ch(b[i][3:0]));
      end else begin
        send_char(b[i]);
      end
    end
    if (asc) begin
      send_char(MFC_CH_CR);
      send_char(MFC_CH_LF);
    end
    release_line(gap);
  endtask
endmodule

/* verification/modbus_frame_check_and_error_reply_test.sv */
// Testbench of the frame check and exception reply block
module modbus_frame_check_and_error_reply_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mfc_pkg::*;
  logic clk_sys, rst, ascii_mode, rx_valid, byte_valid, frame_good, frame_bad;
  logic exec_done, tx_valid, tx_ready;
  logic stall = 1'b0;
  logic tx_v_q = 1'b0;
  logic [7:0] tx_d_q = 8'h00;
  logic [15:0] exp_hd[$];
  logic [7:0] station_no, rx_data, byte_data, exec_code, tx_data, st, fn;
  logic [15:0] char_cycles;
  mfc_hdr_t frame_hdr;
  logic [7:0] exp_byte[$], exp_vd[$], exp_tx[$], fr[$];
  logic [31:0] rnd = 32'h8679;
  int mismatches = 0;
  int n_compared = 0;

  mfc_top u_dut (.clk_sys(clk_sys), .rst(rst), .ascii_mode(ascii_mode),
    .station_no(station_no), .char_cycles(char_cycles), .rx_valid(rx_valid),
    .rx_data(rx_data), .byte_valid(byte_valid), .byte_data(byte_data),
    .frame_good(frame_good), .frame_bad(frame_bad), .frame_hdr(frame_hdr),
    .exec_done(exec_done), .exec_code(exec_code), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  mfc_master_model u_host (.clk_sys(clk_sys), .stall(stall), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));

  // Clock and random stalls
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  always @(negedge clk_sys) begin
    rnd = xorshift(rnd);
    stall <= rnd[0] & rnd[1];
  end
  function automatic logic [7:0] lrc8(input logic [7:0] b[$]);
    logic [7:0] s;
    s = 8'h00;
    foreach (b[i]) s = s + b[i];
    return ~s + 8'h01;
  endfunction
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c[7:0] = c[7:0] ^ b[i];
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic note(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got);
    note(got, exp_byte.size() != 0 ? exp_byte.pop_front() : 8'hxx);
  endtask
  task automatic cmp_verdict(input logic [7:0] got);
    note(got, exp_vd.size() != 0 ? exp_vd.pop_front() : 8'hxx);
  endtask
  task automatic cmp_tx(input logic [7:0] got);
    note(got, exp_tx.size() != 0 ? exp_tx.pop_front() : 8'hxx);
  endtask
  task automatic cmp_hdr(input logic [15:0] got);
    note(got, exp_hd.size() != 0 ? exp_hd.pop_front() : 16'hxxxx);
  endtask
  // Watch the outputs, oldest note first
  always @(negedge clk_sys) begin
    if (rst === 1'b0) begin
      if (byte_valid !== 1'b0) cmp_byte(byte_data);
      if ((frame_good | frame_bad) !== 1'b0) cmp_verdict({6'h00, frame_bad, frame_good});
      if (frame_good !== 1'b0) cmp_hdr(frame_hdr);
      // Char shown at the last fall, taken at the rise in between
      if ((tx_v_q & tx_ready) !== 1'b0) cmp_tx(tx_d_q);
    end
    tx_v_q = tx_valid;
    tx_d_q = tx_data;
  end
  task automatic wait_empty();
    int n;
    n = 0;
    while (exp_byte.size() + exp_vd.size() + exp_tx.size() + exp_hd.size() != 0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      end_sim();
    end else begin
      repeat (12) @(negedge clk_sys);
    end
  endtask
  // Append check, note expected bytes and verdict, send
  task automatic frame(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    st = b[0];
    fn = b[1];
    c = crc16(b);
    if (ascii_mode) begin
      b.push_back(lrc8(b));
    end else begin
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
    end
    b[b.size() - 1] = b[b.size() - 1] ^ {7'h00, bad};
    if (st == station_no || st == MFC_BCAST_ADDR) begin
      foreach (b[i]) exp_byte.push_back(b[i]);
      exp_vd.push_back(bad ? 8'h02 : 8'h01);
      if (!bad) exp_hd.push_back({st, fn});
    end
    u_host.send_frame(b, ascii_mode, 60);
    wait_empty();
  endtask
  // Executor outcome and the reply it should bring
  task automatic exec(input logic [7:0] code);
    logic [7:0] r[$];
    logic [15:0] c;
    r = '{st, fn | MFC_EXC_FLAG, code};
    c = crc16(r);
    if (code != MFC_ERR_NONE && st != MFC_BCAST_ADDR) begin
      if (ascii_mode) begin
        r.push_back(lrc8(r));
        exp_tx.push_back(MFC_CH_START);
        foreach (r[i]) exp_tx.push_back(u_host.hex_ch(r[i][7:4]));
        for (int i = 0; i < 4; i++) exp_tx.insert(2 * i + 2, u_host.hex_ch(r[i][3:0]));
        exp_tx.push_back(MFC_CH_CR);
        exp_tx.push_back(MFC_CH_LF);
      end else begin
        r.push_back(c[7:0]);
        r.push_back(c[15:8]);
        foreach (r[i]) exp_tx.push_back(r[i]);
      end
    end
    @(negedge clk_sys);
    exec_done = 1'b1;
    exec_code = code;
    @(negedge clk_sys);
    exec_done = 1'b0;
    wait_empty();
  endtask
  initial begin
    repeat (60000) @(negedge clk_sys);
    mismatches++;
    $display("timeout reached");
    end_sim();
  end
  initial begin
    rst = 1'b1;
    ascii_mode = 1'b1;
    station_no = 8'h01;
    char_cycles = 16'h000a;
    exec_done = 1'b0;
    exec_code = 8'h00;
    repeat (8) @(negedge clk_sys);
    rst = 1'b0;
    fr = '{8'h01, 8'h03, 8'h02, 8'h01, 8'h00, 8'h01};
    frame(fr, 1'b0);
    exec(MFC_ERR_RANGE);
    frame(fr, 1'b1);
    fr[0] = 8'h05;
    frame(fr, 1'b0);
    $display("test ascii done");
    ascii_mode = 1'b0;
    fr = '{8'h01, 8'h03, 8'h01, 8'h01, 8'h00, 8'h02};
    for (int k = 0; k < 5; k++) begin
      frame(fr, 1'b0);
      exec(k[7:0]);
      fr[4] = rnd[7:0];
      fr[5] = rnd[15:8];
    end
    fr[0] = MFC_BCAST_ADDR;
    frame(fr, 1'b0);
    exec(MFC_ERR_ADDR);
    fr[0] = 8'h01;
    frame(fr, 1'b1);
    $display("test rtu done");
    end_sim();
  end
endmodule
